// >>> rtl/calmt_counter.sv
// down counter that times the execution of one instruction
`timescale 1ns/1ps
`default_nettype none
module calmt_counter
#(
	parameter int W = 4
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	output logic [W-1:0] count,
	output logic last
);
	logic [W-1:0] next_count;

	// load on accept, otherwise count down to zero
	always_comb
	begin
		next_count = count;
		if (load)
			next_count = load_value;
		else if (count != '0)
			next_count = count - W'(1);
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			count <= '0;
		else
			count <= next_count;
	end

	assign last = (count == W'(1));
endmodule : calmt_counter
`default_nettype wire

// >>> rtl/calmt_decoder.sv
// instruction length and cycle-timing decoder, arithmetic/logic/move groups
`timescale 1ns/1ps
`default_nettype none
module calmt_decoder
	import calmt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic pgm_write_enable,
	input wire logic pgm_erase_enable,
	output logic op_ready,
	output logic busy,
	output logic [1:0] instr_len,
	output logic [3:0] instr_cycles,
	output logic instr_known,
	output logic retire,
	output logic ext_data_read_strobe,
	output logic ext_data_write_strobe,
	output logic code_byte_read_strobe,
	output logic pgm_write_strobe,
	output logic pgm_erase_strobe
);
	// -------------------------------------------------------------------
	// opcode lookup
	// -------------------------------------------------------------------
	// length, cycles and class for one opcode; unlisted groups flag unknown
	function automatic calmt_dec_t lookup(input logic [7:0] op);
		calmt_dec_t r;
		logic [3:0] hi;
		logic [3:0] lo;
		r = '{1'b1, LEN_1, CYC_1, CLS_NONE};
		hi = op[7:4];
		lo = op[3:0];
		if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && lo >= 4'h4)
		begin
			// add, add-carry, subtract-borrow
			if (lo == 4'h4 || lo == 4'h5)
				r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
			else if (lo == 4'h6 || lo == 4'h7)
				r = '{1'b1, LEN_1, CYC_2, CLS_NONE}; // [RQ2]
		end
		else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo >= 4'h2)
		begin
			// and, or, exclusive-or
			if (lo == 4'h3)
				r = '{1'b1, LEN_3, CYC_3, CLS_NONE}; // [RQ3] [RQ4]
			else if (lo <= 4'h5)
				r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
			else if (lo <= 4'h7)
				r = '{1'b1, LEN_1, CYC_2, CLS_NONE};
		end
		else if ((hi == 4'h0 || hi == 4'h1) && lo >= 4'h4)
		begin
			// increment and decrement
			if (lo == 4'h5)
				r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
			else if (lo == 4'h6 || lo == 4'h7)
				r = '{1'b1, LEN_1, CYC_2, CLS_NONE};
		end
		else
		begin
			casez (op)
				OP_NOP, OP_UNUSED: r = '{1'b1, LEN_1, CYC_1, CLS_NONE}; // [RQ16]
				OP_RL, OP_RLC, OP_RR, OP_RRC:
					r = '{1'b1, LEN_1, CYC_1, CLS_NONE}; // [RQ11]
				8'hA3, 8'hD4, 8'hE4, 8'hC4: r = '{1'b1, LEN_1, CYC_1, CLS_NONE};
				8'hA4: r = '{1'b1, LEN_1, CYC_4, CLS_NONE};
				8'h84: r = '{1'b1, LEN_1, CYC_8, CLS_NONE};
				8'hF4: r = '{1'b1, LEN_1, CYC_2, CLS_NONE};
				8'b1110_1???, 8'b1111_1???: r = '{1'b1, LEN_1, CYC_1, CLS_NONE};
				8'b1100_1???: r = '{1'b1, LEN_1, CYC_1, CLS_NONE};
				8'hE5, 8'h74, 8'hF5: r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
				8'b1010_1???, 8'b0111_1???: r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
				8'b1000_1???, 8'b1000_011?: r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
				8'b1010_011?: r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
				8'b0111_011?: r = '{1'b1, LEN_2, CYC_2, CLS_NONE}; // [RQ10]
				8'b1110_011?, 8'b1111_011?: r = '{1'b1, LEN_1, CYC_2, CLS_NONE};
				OP_MOV_DIR_DIR: r = '{1'b1, LEN_3, CYC_3, CLS_NONE}; // [RQ9]
				8'h75: r = '{1'b1, LEN_3, CYC_3, CLS_NONE};
				OP_LOAD_DP: r = '{1'b1, LEN_3, CYC_3, CLS_NONE}; // [RQ8]
				OP_CODE_DP, OP_CODE_PC: r = '{1'b1, LEN_1, CYC_3, CLS_CODE}; // [RQ7]
				OP_XREAD_R0, OP_XREAD_R1, OP_XREAD_DP:
					r = '{1'b1, LEN_1, CYC_3, CLS_XREAD}; // [RQ5]
				OP_XWRITE_R0, OP_XWRITE_R1, OP_XWRITE_DP:
					r = '{1'b1, LEN_1, CYC_3, CLS_XWRITE}; // [RQ6]
				OP_PUSH, OP_POP: r = '{1'b1, LEN_2, CYC_2, CLS_NONE}; // [RQ12]
				8'hC5: r = '{1'b1, LEN_2, CYC_2, CLS_NONE};
				8'b1100_011?: r = '{1'b1, LEN_1, CYC_2, CLS_NONE}; // [RQ13]
				8'b1101_011?: r = '{1'b1, LEN_1, CYC_2, CLS_NONE}; // [RQ14]
				default: r = '{1'b0, LEN_1, CYC_1, CLS_NONE};
			endcase
		end
		return r;
	endfunction : lookup

	// -------------------------------------------------------------------
	// sequencer
	// -------------------------------------------------------------------
	calmt_state_t state;
	calmt_state_t next_state;
	calmt_dec_t dec_now;
	calmt_dec_t dec_held;
	logic accept;
	logic [3:0] count;
	logic last;

	assign dec_now = lookup(op_byte);
	assign busy = (state == ST_EXEC);
	// a new opcode may enter in the cycle the previous one retires
	assign retire = busy && last; // [RQ15]
	assign op_ready = !busy || retire;
	assign accept = op_valid && op_ready;

	// idle until an opcode is taken, then run its cycle count
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (accept)
					next_state = ST_EXEC;
			ST_EXEC:
				if (retire && !accept)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// cycle timer, loaded with the decoded count on accept
	calmt_counter #(.W(4)) u_timer
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.load(accept),
		.load_value(dec_now.cyc), // [RQ15]
		.count(count),
		.last(last)
	);

	// decoded fields held for the running instruction
	calmt_hold #(.W(DEC_W), .INIT(DEC_RESET)) u_hold
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.load(accept),
		.d(dec_now),
		.q(dec_held)
	);

	// -------------------------------------------------------------------
	// reported fields and side effects
	// -------------------------------------------------------------------
	// length and cycle count of the running instruction
	assign instr_len = dec_held.len; // [RQ17]
	assign instr_cycles = dec_held.cyc; // [RQ17]
	assign instr_known = dec_held.known;

	// external moves: writes go to program memory when software enabled it
	assign ext_data_read_strobe = retire && (dec_held.cls == CLS_XREAD);
	assign code_byte_read_strobe = retire && (dec_held.cls == CLS_CODE);
	assign pgm_write_strobe = retire && (dec_held.cls == CLS_XWRITE)
		&& pgm_write_enable && !pgm_erase_enable; // [RQ1]
	assign pgm_erase_strobe = retire && (dec_held.cls == CLS_XWRITE)
		&& pgm_write_enable && pgm_erase_enable; // [RQ1]
	assign ext_data_write_strobe = retire && (dec_held.cls == CLS_XWRITE)
		&& !pgm_write_enable; // [RQ1]

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	// cycles since the last accept, for the timing checks
	logic [3:0] elapsed;
	logic [3:0] next_elapsed;

	// restart at one on accept, then count up and stop at the top
	always_comb
	begin
		next_elapsed = elapsed;
		if (accept)
			next_elapsed = CYC_1;
		else if (elapsed != 4'hF)
			next_elapsed = elapsed + CYC_1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			elapsed <= CYC_ZERO;
		else
			elapsed <= next_elapsed;
	end

	add_indirect_a: // [RQ2]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_ADD_IND)
		|=> instr_len == LEN_1 && instr_cycles == CYC_2 ##1 retire)
	else $error("indirect add not one byte two cycles");

	logic_dir_imm_a: // [RQ3]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_ORL_DIR_IMM || op_byte == OP_XRL_DIR_IMM)
		|=> (instr_len == LEN_3 && !retire) [*2] ##1 retire)
	else $error("or/xor immediate to direct timing wrong");

	and_dir_imm_a: // [RQ4]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_ANL_DIR_IMM)
		|=> ##2 retire && instr_len == LEN_3 && elapsed == CYC_3)
	else $error("and immediate to direct timing wrong");

	ext_read_a: // [RQ5]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_XREAD_R0 || op_byte == OP_XREAD_R1)
		|=> !ext_data_read_strobe [*2] ##1 ext_data_read_strobe
		&& instr_len == LEN_1)
	else $error("external read timing wrong");

	ext_write_a: // [RQ6]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_XWRITE_DP)
		|=> instr_len == LEN_1 ##2 retire
		&& (ext_data_write_strobe || pgm_write_strobe || pgm_erase_strobe))
	else $error("external write timing wrong");

	pgm_select_a: // [RQ1]
	assert property (@(posedge ref_clk) disable iff (reset)
		retire && (dec_held.cls == CLS_XWRITE) && pgm_write_enable
		|-> !ext_data_write_strobe && (pgm_write_strobe != pgm_erase_strobe))
	else $error("program memory write steering wrong");

	code_read_a: // [RQ7]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_CODE_DP)
		|=> ##2 code_byte_read_strobe && instr_len == LEN_1)
	else $error("code byte read timing wrong");

	load_dp_a: // [RQ8]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_LOAD_DP)
		|=> instr_len == LEN_3 && instr_cycles == CYC_3 ##2 retire)
	else $error("data pointer load timing wrong");

	move_dir_a: // [RQ9]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_MOV_DIR_DIR)
		|=> (busy && !retire) [*2] ##1 retire && instr_len == LEN_3)
	else $error("direct to direct move timing wrong");

	store_ind_a: // [RQ10]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_MOV_IND_IMM)
		|=> !retire ##1 retire && instr_len == LEN_2)
	else $error("immediate to indirect store timing wrong");

	rotate_a: // [RQ11]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_RL || op_byte == OP_RLC
		|| op_byte == OP_RR || op_byte == OP_RRC)
		|=> retire && instr_len == LEN_1 && instr_cycles == CYC_1)
	else $error("rotate not single cycle");

	stack_op_a: // [RQ12]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_PUSH || op_byte == OP_POP)
		|=> instr_len == LEN_2 && !retire ##1 retire)
	else $error("push/pop timing wrong");

	exchange_a: // [RQ13]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_XCH_IND)
		|=> instr_len == LEN_1 && instr_cycles == CYC_2 ##1 retire)
	else $error("indirect exchange timing wrong");

	nibble_xch_a: // [RQ14]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_NIBBLE_XCH_IND)
		|=> instr_len == LEN_1 ##1 retire && elapsed == CYC_2)
	else $error("low nibble exchange timing wrong");

	cycle_count_a: // [RQ15]
	assert property (@(posedge ref_clk) disable iff (reset)
		retire |-> elapsed == instr_cycles)
	else $error("retire not at decoded cycle count");

	unused_nop_a: // [RQ16]
	assert property (@(posedge ref_clk) disable iff (reset)
		accept && (op_byte == OP_UNUSED)
		|=> retire && instr_known && instr_len == LEN_1)
	else $error("unused opcode differs from no-operation");

	report_hold_a: // [RQ17]
	assert property (@(posedge ref_clk) disable iff (reset)
		busy && !retire |=> $stable(instr_len) && $stable(instr_cycles))
	else $error("reported fields changed mid instruction");

	strobe_retire_a: // [RQ17]
	assert property (@(posedge ref_clk) disable iff (reset)
		!retire |-> !(ext_data_read_strobe || ext_data_write_strobe
		|| code_byte_read_strobe || pgm_write_strobe || pgm_erase_strobe))
	else $error("side-effect strobe outside retire");

	ready_hold_a: // [RQ15]
	assert property (@(posedge ref_clk) disable iff (reset)
		busy && !retire |-> !op_ready ##1 busy)
	else $error("opcode taken before retire");
endmodule : calmt_decoder
`default_nettype wire

// >>> rtl/calmt_hold.sv
// register that holds the decoded fields of the running instruction
`timescale 1ns/1ps
`default_nettype none
module calmt_hold
#(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] next_q;

	// take new contents only when loaded
	always_comb
	begin
		next_q = load ? d : q;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			q <= INIT;
		else
			q <= next_q;
	end
endmodule : calmt_hold
`default_nettype wire

// >>> rtl/calmt_pkg.sv
// constants and types for the instruction length and timing decoder
// -----------------------------------------------------------------------
// Overview of operation
// (RQ1) External data moves that write may also write or erase program memory.
// (RQ2) Add, add-carry, subtract-borrow, indirect RAM: one byte, two cycles.
// (RQ3) AND, OR, XOR immediate into direct byte: three bytes, three cycles.
// (RQ4) AND immediate into direct byte: three bytes, three cycles.
// (RQ5) External read via 8-bit register address: one byte, three cycles.
// (RQ6) External write via 16-bit data pointer: one byte, three cycles.
// (RQ7) Code byte read from data pointer plus A: one byte, three cycles.
// (RQ8) Load data pointer with immediate: three bytes, three cycles.
// (RQ9) Move direct byte to direct byte: three bytes, three cycles.
// (RQ10) Store immediate into indirect RAM: two bytes, two cycles.
// (RQ11) Accumulator rotates, plain or through carry: one byte, one cycle.
// (RQ12) Push and pop of a direct byte: two bytes, two cycles each.
// (RQ13) Exchange accumulator with indirect RAM: one byte, two cycles.
// (RQ14) Low nibble exchange with indirect RAM: one byte, two cycles.
// (RQ15) Timing counts clock cycles only; most take as many cycles as bytes.
// (RQ16) The single unused opcode behaves exactly like no-operation.
// (RQ17) Decoder reports length and cycle count for every opcode it takes.
// -----------------------------------------------------------------------
package calmt_pkg;
	// instruction lengths in program bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	// execution times in system clock cycles
	localparam logic [3:0] CYC_1 = 4'h1;
	localparam logic [3:0] CYC_2 = 4'h2;
	localparam logic [3:0] CYC_3 = 4'h3;
	localparam logic [3:0] CYC_4 = 4'h4;
	localparam logic [3:0] CYC_8 = 4'h8;
	localparam logic [3:0] CYC_ZERO = 4'h0;
	// opcodes named by the lookup and the checks
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_UNUSED = 8'hA5;
	localparam logic [7:0] OP_ADD_IND = 8'h26;
	localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
	localparam logic [7:0] OP_ORL_DIR_IMM = 8'h43;
	localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
	localparam logic [7:0] OP_XREAD_R0 = 8'hE2;
	localparam logic [7:0] OP_XREAD_R1 = 8'hE3;
	localparam logic [7:0] OP_XREAD_DP = 8'hE0;
	localparam logic [7:0] OP_XWRITE_R0 = 8'hF2;
	localparam logic [7:0] OP_XWRITE_R1 = 8'hF3;
	localparam logic [7:0] OP_XWRITE_DP = 8'hF0;
	localparam logic [7:0] OP_CODE_DP = 8'h93;
	localparam logic [7:0] OP_CODE_PC = 8'h83;
	localparam logic [7:0] OP_LOAD_DP = 8'h90;
	localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_RL = 8'h23;
	localparam logic [7:0] OP_RLC = 8'h33;
	localparam logic [7:0] OP_RR = 8'h03;
	localparam logic [7:0] OP_RRC = 8'h13;
	localparam logic [7:0] OP_PUSH = 8'hC0;
	localparam logic [7:0] OP_POP = 8'hD0;
	localparam logic [7:0] OP_XCH_IND = 8'hC6;
	localparam logic [7:0] OP_NIBBLE_XCH_IND = 8'hD6;
	localparam logic [7:0] OP_MOV_IND_IMM = 8'h76;
	// side-effect classes of an instruction
	typedef enum logic [1:0]
	{
		CLS_NONE = 2'h0,
		CLS_XREAD = 2'h1,
		CLS_XWRITE = 2'h2,
		CLS_CODE = 2'h3
	} calmt_cls_t;
	// decoded view of one opcode
	typedef struct packed
	{
		logic known;
		logic [1:0] len;
		logic [3:0] cyc;
		calmt_cls_t cls;
	} calmt_dec_t;
	localparam int DEC_W = 9;
	localparam calmt_dec_t DEC_RESET = '{1'b0, LEN_1, CYC_1, CLS_NONE};
	// sequencer states, one-hot
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h1,
		ST_EXEC = 2'h2
	} calmt_state_t;
endpackage : calmt_pkg

// >>> sim/tb_top.sv
// self-checking testbench for the instruction length and timing decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import calmt_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic op_valid = 1'b0;
	logic [7:0] op_byte = 8'h00;
	logic pgm_write_enable = 1'b0;
	logic pgm_erase_enable = 1'b0;
	logic op_ready, busy, instr_known, retire;
	logic [1:0] instr_len;
	logic [3:0] instr_cycles;
	logic ext_data_read_strobe, ext_data_write_strobe;
	logic code_byte_read_strobe, pgm_write_strobe, pgm_erase_strobe;
	logic [4:0] strobes;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;

	// strobes packed as read, write, code, program write, program erase
	assign strobes = {ext_data_read_strobe, ext_data_write_strobe,
		code_byte_read_strobe, pgm_write_strobe, pgm_erase_strobe};

	calmt_decoder calmt_decoder_i
	(
		.ref_clk(ref_clk),
		.reset(reset),
		.op_valid(op_valid),
		.op_byte(op_byte),
		.pgm_write_enable(pgm_write_enable),
		.pgm_erase_enable(pgm_erase_enable),
		.op_ready(op_ready),
		.busy(busy),
		.instr_len(instr_len),
		.instr_cycles(instr_cycles),
		.instr_known(instr_known),
		.retire(retire),
		.ext_data_read_strobe(ext_data_read_strobe),
		.ext_data_write_strobe(ext_data_write_strobe),
		.code_byte_read_strobe(code_byte_read_strobe),
		.pgm_write_strobe(pgm_write_strobe),
		.pgm_erase_strobe(pgm_erase_strobe)
	);

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	always #4 ref_clk = ~ref_clk;

	// the whole run needs about 155 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			results();
		end
	end

	// ------------------------------------------------------------
	// compare and drive helpers
	// ------------------------------------------------------------
	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_flag

	// offer one opcode, check decode, count cycles up to retire
	task automatic ex(input logic [7:0] op, input logic [1:0] len,
		input logic [3:0] cyc, input logic known, input logic [4:0] str);
		int n;
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_byte = op;
		check_flag(op_ready, 1'b1);
		@(negedge ref_clk);
		op_valid = 1'b0;
		check_val({6'h00, instr_len}, {6'h00, len});
		check_val({4'h0, instr_cycles}, {4'h0, cyc});
		check_flag(instr_known, known);
		check_flag(busy, 1'b1);
		n = 1;
		while (retire !== 1'b1 && n < 12)
		begin
			check_val({3'h0, strobes}, 8'h00);
			@(negedge ref_clk);
			n++;
		end
		check_flag(retire, 1'b1);
		check_val(8'(n), {4'h0, cyc});
		check_val({3'h0, strobes}, {3'h0, str});
	endtask : ex

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_arith();
		ex(8'h26, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'h27, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'h36, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'h37, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'h96, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'h97, LEN_1, CYC_2, 1'b1, 5'h00);
		$display("test arith done");
	endtask : test_arith

	task automatic test_logic();
		ex(8'h53, LEN_3, CYC_3, 1'b1, 5'h00);
		ex(8'h43, LEN_3, CYC_3, 1'b1, 5'h00);
		ex(8'h63, LEN_3, CYC_3, 1'b1, 5'h00);
		$display("test logic done");
	endtask : test_logic

	task automatic test_xmove();
		ex(8'hE2, LEN_1, CYC_3, 1'b1, 5'h10);
		ex(8'hE3, LEN_1, CYC_3, 1'b1, 5'h10);
		ex(8'hE0, LEN_1, CYC_3, 1'b1, 5'h10);
		ex(8'hF0, LEN_1, CYC_3, 1'b1, 5'h08);
		ex(8'hF2, LEN_1, CYC_3, 1'b1, 5'h08);
		ex(8'h93, LEN_1, CYC_3, 1'b1, 5'h04);
		ex(8'h83, LEN_1, CYC_3, 1'b1, 5'h04);
		// enables move only once the retire cycle has passed
		@(negedge ref_clk);
		pgm_write_enable = 1'b1;
		ex(8'hF0, LEN_1, CYC_3, 1'b1, 5'h02);
		ex(8'hF2, LEN_1, CYC_3, 1'b1, 5'h02);
		@(negedge ref_clk);
		pgm_erase_enable = 1'b1;
		ex(8'hF3, LEN_1, CYC_3, 1'b1, 5'h01);
		ex(8'hE2, LEN_1, CYC_3, 1'b1, 5'h10);
		@(negedge ref_clk);
		pgm_write_enable = 1'b0;
		ex(8'hF3, LEN_1, CYC_3, 1'b1, 5'h08);
		@(negedge ref_clk);
		pgm_erase_enable = 1'b0;
		$display("test xmove done");
	endtask : test_xmove

	task automatic test_move();
		ex(8'h90, LEN_3, CYC_3, 1'b1, 5'h00);
		ex(8'h85, LEN_3, CYC_3, 1'b1, 5'h00);
		ex(8'h76, LEN_2, CYC_2, 1'b1, 5'h00);
		ex(8'h77, LEN_2, CYC_2, 1'b1, 5'h00);
		ex(8'h23, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'h33, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'h03, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'h13, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'hC0, LEN_2, CYC_2, 1'b1, 5'h00);
		ex(8'hD0, LEN_2, CYC_2, 1'b1, 5'h00);
		ex(8'hC6, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'hC7, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'hD6, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'hD7, LEN_1, CYC_2, 1'b1, 5'h00);
		ex(8'hA4, LEN_1, CYC_4, 1'b1, 5'h00);
		ex(8'h84, LEN_1, CYC_8, 1'b1, 5'h00);
		$display("test move done");
	endtask : test_move

	task automatic test_unused();
		ex(8'hA5, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'h00, LEN_1, CYC_1, 1'b1, 5'h00);
		ex(8'h02, LEN_1, CYC_1, 1'b0, 5'h00);
		$display("test unused done");
	endtask : test_unused

	// offer early while busy, then back to back on the retire cycle
	task automatic test_b2b();
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_byte = 8'hC6;
		@(negedge ref_clk);
		op_byte = 8'h90;
		check_flag(op_ready, 1'b0);
		check_flag(retire, 1'b0);
		@(negedge ref_clk);
		check_flag(retire, 1'b1);
		check_flag(op_ready, 1'b1);
		@(negedge ref_clk);
		op_valid = 1'b0;
		check_val({6'h00, instr_len}, {6'h00, LEN_3});
		check_flag(retire, 1'b0);
		repeat (2) @(negedge ref_clk);
		check_flag(retire, 1'b1);
		$display("test b2b done");
	endtask : test_b2b

	// reset in mid-instruction returns the idle values
	task automatic test_reset();
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_byte = 8'h85;
		@(negedge ref_clk);
		op_valid = 1'b0;
		reset = 1'b1;
		@(negedge ref_clk);
		reset = 1'b0;
		check_flag(busy, 1'b0);
		check_flag(op_ready, 1'b1);
		check_flag(retire, 1'b0);
		check_flag(instr_known, 1'b0);
		check_val({4'h0, instr_cycles}, {4'h0, CYC_1});
		ex(8'h53, LEN_3, CYC_3, 1'b1, 5'h00);
		$display("test reset done");
	endtask : test_reset

	// ------------------------------------------------------------
	// verdict and main sequence
	// ------------------------------------------------------------
	task automatic results();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	initial
	begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		test_arith();
		test_logic();
		test_xmove();
		test_move();
		test_unused();
		test_b2b();
		test_reset();
		results();
	end
endmodule : tb_top
`default_nettype wire
